// >>> inc/lpwc_pkg.sv
// Shared constants for the low-power wake and undervoltage control block.
// Assumes an APB3 register bus with 32-bit data and a 100 MHz pclk.
package lpwc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_MODE     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_TIMEBASE = 8'h0c;
  localparam logic [7:0] ADDR_KEYPAD   = 8'h10;

  // Config register fields
  localparam int CFG_OSC_KEEP_BIT    = 0;
  localparam int CFG_SHORT_RECOV_BIT = 1;
  localparam int CFG_UV_PWR_DIS_BIT  = 2;
  localparam int CFG_UV_RST_DIS_BIT  = 3;
  localparam int CFG_UV_STOP_EN_BIT  = 4;
  localparam int CFG_UV_RANGE_BIT    = 5;
  localparam int CFG_WIDTH           = 6;
  localparam logic [5:0] CFG_RESET   = 6'h00;

  // Mode register commands
  localparam logic [1:0] CMD_WAIT = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;

  // Timebase register fields
  localparam int TB_ENABLE_BIT          = 16;
  localparam logic [15:0] TB_PERIOD_RESET = 16'hffff;

  // Stop recovery counts in oscillator cycles
  localparam int STOP_RECOV_FULL_CYC  = 4096;
  localparam int STOP_RECOV_SHORT_CYC = 32;
  localparam logic [11:0] RECOV_FULL_LOAD  = 12'(STOP_RECOV_FULL_CYC - 1);
  localparam logic [11:0] RECOV_SHORT_LOAD = 12'(STOP_RECOV_SHORT_CYC - 1);

  // Wake sources, index 0 has highest priority
  localparam int NUM_SRC      = 22;
  localparam int SRC_RESET    = 0;
  localparam int SRC_BREAK    = 1;
  localparam int SRC_IRQ      = 2;
  localparam int SRC_CLKGEN   = 3;
  localparam int SRC_FIRST_TIMER     = 4;
  localparam int SRC_SECOND_TIMER_LO  = 7;
  localparam int SRC_SPI      = 10;
  localparam int SRC_SCI      = 12;
  localparam int SRC_KEYPAD   = 15;
  localparam int SRC_ADC      = 16;
  localparam int SRC_TIMEBASE = 17;
  localparam int SRC_SECOND_TIMER_HI  = 18;

  localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
    16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8,
    16'hfff6, 16'hfff4, 16'hfff2,
    16'hfff0, 16'hffee, 16'hffec,
    16'hffea, 16'hffe8,
    16'hffe6, 16'hffe4, 16'hffe2,
    16'hffe0, 16'hffde, 16'hffdc,
    16'hffd2, 16'hffd0, 16'hffce, 16'hffcc
  };
  localparam logic [15:0] VECTOR_RESET = 16'hfffe;

  typedef enum logic [1:0] {
    MODE_RUN     = 2'b00,
    MODE_WAIT    = 2'b01,
    MODE_STOP    = 2'b10,
    MODE_RECOVER = 2'b11
  } lpwc_mode_type;

endpackage

// >>> logic/lpwc_top.sv
// Low-power wake sequencing, stop recovery, timebase and undervoltage control.
// Assumes an APB3 master on pclk; pins and analog comparator outputs are asynchronous.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module lpwc_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_ref_clock,
  input  wire logic        ext_reset_pin_n_in,
  output logic             ext_reset_pin_out,
  output logic             ext_reset_pin_oe,
  input  wire logic        ext_irq_pin_n,
  input  wire logic [7:0]  keypad_pins,
  input  wire logic        emulation_mode,
  input  wire logic        break_req,
  input  wire logic        watchdog_timeout,
  input  wire logic        clock_gen_req,
  input  wire logic [2:0]  first_timer_req,
  input  wire logic [6:0]  second_timer_req,
  input  wire logic [1:0]  spi_req,
  input  wire logic [2:0]  async_serial_req,
  input  wire logic        adc_done_req,
  input  wire logic        below_falling_trip,
  input  wire logic        above_rising_trip,
  output logic             undervolt_monitor_on,
  output logic             undervolt_range_select,
  output logic             cpu_clock_enable,
  output logic             system_clock_enable,
  output logic             clock_gen_enable,
  output logic             timebase_active,
  output logic             cpu_reset,
  output logic [15:0]      wake_vector,
  output logic             wake_strobe
);

  lpwc_pkg::lpwc_mode_type mode;
  lpwc_pkg::lpwc_mode_type next_mode;

  logic [lpwc_pkg::CFG_WIDTH-1:0] config_bits;
  logic [15:0] tb_period;
  logic        tb_enable;
  logic [15:0] tb_count;
  logic        tb_pending;
  logic [7:0]  keypad_polarity_bits;
  logic [11:0] recov_count;
  logic [15:0] held_vector;
  logic        held_is_reset;
  logic        undervolt_flag;
  logic        uv_reset_hold;

  // Two-stage synchronisers for pins and analog levels
  logic [12:0] sync_a;
  logic [12:0] sync_b;
  logic [12:0] sync_c;
  logic [12:0] async_in;

  assign async_in = {osc_ref_clock, ext_reset_pin_n_in, ext_irq_pin_n, keypad_pins,
                     below_falling_trip, above_rising_trip};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Pins idle high, comparator levels idle low
      sync_a <= 13'h1ffc;
      sync_b <= 13'h1ffc;
      sync_c <= 13'h1ffc;
    end
    else
    begin
      sync_a <= async_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  logic       osc_edge;
  logic       rst_pin_low;
  logic       irq_fall;
  logic [7:0] keypad_event;
  logic       vdd_below;
  logic       vdd_above;

  assign osc_edge    = sync_b[12] & ~sync_c[12];
  assign rst_pin_low = ~sync_b[11];
  assign irq_fall    = ~sync_b[10] & sync_c[10];
  assign vdd_below   = sync_b[1];
  assign vdd_above   = sync_b[0];

  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_keypad
      assign keypad_event[k] = keypad_polarity_bits[k] ? (sync_b[2+k] & ~sync_c[2+k])
                                                       : (~sync_b[2+k] & sync_c[2+k]);
    end
  endgenerate

  logic osc_keep;
  logic short_recov;
  logic uv_pwr_dis;
  logic uv_rst_dis;
  logic uv_stop_en;
  logic in_stop;
  logic in_low_power;

  assign osc_keep     = config_bits[lpwc_pkg::CFG_OSC_KEEP_BIT];
  assign short_recov  = config_bits[lpwc_pkg::CFG_SHORT_RECOV_BIT];
  assign uv_pwr_dis   = config_bits[lpwc_pkg::CFG_UV_PWR_DIS_BIT];
  assign uv_rst_dis   = config_bits[lpwc_pkg::CFG_UV_RST_DIS_BIT];
  assign uv_stop_en   = config_bits[lpwc_pkg::CFG_UV_STOP_EN_BIT];
  assign in_stop      = (mode == lpwc_pkg::MODE_STOP) || (mode == lpwc_pkg::MODE_RECOVER);
  assign in_low_power = in_stop || (mode == lpwc_pkg::MODE_WAIT);

  // Monitor on unless power-disabled; stop needs stop-enable
  assign undervolt_monitor_on   = ~uv_pwr_dis & (~in_stop | uv_stop_en);
  assign undervolt_range_select = config_bits[lpwc_pkg::CFG_UV_RANGE_BIT];

  // Timebase runs in run and wait, in stop only with oscillator
  assign timebase_active = tb_enable & (~in_stop | osc_keep);

  // APB decode
  logic apb_access;
  logic apb_write;
  logic tb_blocked;
  logic addr_hit;

  assign apb_access = psel & penable;
  assign apb_write  = apb_access & pwrite;
  // Timebase register hidden in wait and stop
  assign tb_blocked = in_low_power && (paddr == lpwc_pkg::ADDR_TIMEBASE);
  assign addr_hit   = (paddr == lpwc_pkg::ADDR_CONFIG) || (paddr == lpwc_pkg::ADDR_MODE) ||
                      (paddr == lpwc_pkg::ADDR_STATUS) || (paddr == lpwc_pkg::ADDR_TIMEBASE) ||
                      (paddr == lpwc_pkg::ADDR_KEYPAD);
  assign pready     = 1'b1;
  assign pslverr    = apb_access & (~addr_hit | tb_blocked);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        lpwc_pkg::ADDR_CONFIG:   prdata[lpwc_pkg::CFG_WIDTH-1:0] <= config_bits;
        lpwc_pkg::ADDR_MODE:     prdata[1:0] <= mode;
        lpwc_pkg::ADDR_STATUS:   prdata <= {held_vector, 14'h0000, uv_reset_hold, undervolt_flag};
        lpwc_pkg::ADDR_TIMEBASE:
          if (!in_low_power)
            prdata <= {15'h0000, tb_enable, tb_period};
        lpwc_pkg::ADDR_KEYPAD:   prdata[7:0] <= keypad_polarity_bits;
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      // Monitor enabled, low range after power-on
      config_bits <= lpwc_pkg::CFG_RESET;
    else if (apb_write && paddr == lpwc_pkg::ADDR_CONFIG)
      config_bits <= pwdata[lpwc_pkg::CFG_WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      keypad_polarity_bits <= 8'h00;
    else if (apb_write && paddr == lpwc_pkg::ADDR_KEYPAD)
      keypad_polarity_bits <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tb_period <= lpwc_pkg::TB_PERIOD_RESET;
      tb_enable <= 1'b0;
    end
    else if (apb_write && paddr == lpwc_pkg::ADDR_TIMEBASE && !in_low_power)
    begin
      tb_period <= pwdata[15:0];
      tb_enable <= pwdata[lpwc_pkg::TB_ENABLE_BIT];
    end
  end

  // Timebase counter
  logic tb_roll;
  assign tb_roll = timebase_active && (tb_count == tb_period);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tb_count <= 16'h0000;
    else if (!tb_enable || tb_roll)
      tb_count <= 16'h0000;
    else if (timebase_active)
      tb_count <= tb_count + 16'h0001;
  end

  logic wake_taken;

  // Rollover pending until a wake consumes it or the timebase is disabled; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tb_pending <= 1'b0;
    else if (tb_roll)
      tb_pending <= 1'b1;
    else if (wake_taken || !tb_enable)
      tb_pending <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      undervolt_flag <= 1'b0;
    else if (undervolt_monitor_on && vdd_below)
      undervolt_flag <= 1'b1;
    else if (undervolt_monitor_on && vdd_above)
      undervolt_flag <= 1'b0;
  end

  // Undervoltage reset held until above rising level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uv_reset_hold <= 1'b0;
    else if (undervolt_monitor_on && !uv_rst_dis && vdd_below)
      uv_reset_hold <= 1'b1;
    else if (vdd_above)
      uv_reset_hold <= 1'b0;
  end

  // Drive reset pin low while held
  assign ext_reset_pin_out = 1'b0;
  assign ext_reset_pin_oe  = uv_reset_hold;

  // Wake requests by priority
  logic [lpwc_pkg::NUM_SRC-1:0] wake_req;
  logic wait_only;
  assign wait_only = (mode == lpwc_pkg::MODE_WAIT) || (mode == lpwc_pkg::MODE_RUN);

  always_comb
  begin
    wake_req = '0;
    wake_req[lpwc_pkg::SRC_RESET] = rst_pin_low | uv_reset_hold | (watchdog_timeout & ~in_stop);
    wake_req[lpwc_pkg::SRC_BREAK] = break_req & emulation_mode;
    wake_req[lpwc_pkg::SRC_IRQ] = irq_fall;
    wake_req[lpwc_pkg::SRC_CLKGEN] = clock_gen_req & wait_only;
    // First timer: channel 0, channel 1, overflow
    wake_req[lpwc_pkg::SRC_FIRST_TIMER +: 3] = first_timer_req & {3{wait_only}};
    // Second timer: channels 0, 1, overflow, then 2 to 5
    wake_req[lpwc_pkg::SRC_SECOND_TIMER_LO +: 3] = second_timer_req[2:0] & {3{wait_only}};
    wake_req[lpwc_pkg::SRC_SECOND_TIMER_HI +: 4] = second_timer_req[6:3] & {4{wait_only}};
    wake_req[lpwc_pkg::SRC_SPI +: 2] = spi_req & {2{wait_only}};
    wake_req[lpwc_pkg::SRC_SCI +: 3] = async_serial_req & {3{wait_only}};
    wake_req[lpwc_pkg::SRC_KEYPAD] = |keypad_event;
    wake_req[lpwc_pkg::SRC_ADC] = adc_done_req & wait_only;
    wake_req[lpwc_pkg::SRC_TIMEBASE] = tb_pending | tb_roll;
  end

  logic [15:0] picked_vector;
  logic        any_wake;

  always_comb
  begin
    picked_vector = lpwc_pkg::VECTOR_RESET;
    for (int i = lpwc_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (wake_req[i])
        picked_vector = lpwc_pkg::VECTOR_TABLE[i];
    end
  end

  assign any_wake   = |wake_req;
  assign wake_taken = any_wake && (mode == lpwc_pkg::MODE_WAIT || mode == lpwc_pkg::MODE_STOP);

  // Mode sequencing
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      lpwc_pkg::MODE_RUN:
        if (apb_write && paddr == lpwc_pkg::ADDR_MODE && !wake_req[lpwc_pkg::SRC_RESET])
        begin
          if (pwdata[1:0] == lpwc_pkg::CMD_WAIT)
            next_mode = lpwc_pkg::MODE_WAIT;
          else if (pwdata[1:0] == lpwc_pkg::CMD_STOP)
            next_mode = lpwc_pkg::MODE_STOP;
        end
      lpwc_pkg::MODE_WAIT:
        if (any_wake)
          next_mode = lpwc_pkg::MODE_RUN;
      lpwc_pkg::MODE_STOP:
        if (any_wake)
          next_mode = lpwc_pkg::MODE_RECOVER;
      lpwc_pkg::MODE_RECOVER:
        if (osc_edge && recov_count == 12'h000)
          next_mode = lpwc_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= lpwc_pkg::MODE_RUN;
    else
      mode <= next_mode;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      recov_count <= lpwc_pkg::RECOV_FULL_LOAD;
    else if (mode == lpwc_pkg::MODE_STOP)
      recov_count <= short_recov ? lpwc_pkg::RECOV_SHORT_LOAD : lpwc_pkg::RECOV_FULL_LOAD;
    else if (mode == lpwc_pkg::MODE_RECOVER && osc_edge && recov_count != 12'h000)
      recov_count <= recov_count - 12'h001;
  end

  // Vector latched at wake; a reset during recovery overrides
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held_vector   <= lpwc_pkg::VECTOR_RESET;
      held_is_reset <= 1'b0;
    end
    else if (wake_taken)
    begin
      held_vector   <= picked_vector;
      held_is_reset <= wake_req[lpwc_pkg::SRC_RESET];
    end
    // Reset overrides a pending interrupt vector
    else if (mode == lpwc_pkg::MODE_RECOVER && wake_req[lpwc_pkg::SRC_RESET])
    begin
      held_vector   <= lpwc_pkg::VECTOR_RESET;
      held_is_reset <= 1'b1;
    end
    else if (mode == lpwc_pkg::MODE_RUN && wake_req[lpwc_pkg::SRC_RESET])
    begin
      held_vector   <= lpwc_pkg::VECTOR_RESET;
      held_is_reset <= 1'b1;
    end
  end

  logic finish_wake;
  assign finish_wake = (mode == lpwc_pkg::MODE_WAIT && any_wake) ||
                       (mode == lpwc_pkg::MODE_RECOVER && next_mode == lpwc_pkg::MODE_RUN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_vector <= lpwc_pkg::VECTOR_RESET;
      wake_strobe <= 1'b0;
    end
    else if (finish_wake)
    begin
      wake_vector <= (mode == lpwc_pkg::MODE_WAIT) ? picked_vector : held_vector;
      wake_strobe <= 1'b1;
    end
    else
      wake_strobe <= 1'b0;
  end

  // CPU reset during reset sources or a pending reset wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_reset <= 1'b1;
    else
      cpu_reset <= wake_req[lpwc_pkg::SRC_RESET] |
                   (mode == lpwc_pkg::MODE_RECOVER && held_is_reset);
  end

  // Clock gating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_clock_enable    <= 1'b1;
      system_clock_enable <= 1'b1;
      clock_gen_enable    <= 1'b1;
    end
    else
    begin
      cpu_clock_enable    <= (next_mode == lpwc_pkg::MODE_RUN);
      // System clocks off through stop and recovery
      system_clock_enable <= (next_mode == lpwc_pkg::MODE_RUN) || (next_mode == lpwc_pkg::MODE_WAIT);
      // Generator off in stop unless oscillator kept
      clock_gen_enable    <= !(next_mode == lpwc_pkg::MODE_STOP && !osc_keep);
    end
  end

endmodule

// >>> tb/lpwc_top_properties.sv
// Port checks for the wake and undervoltage block.
// Bound into lpwc_top; sees its ports only.
`timescale 1ns/1ns
module lpwc_top_properties
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        ext_reset_pin_out,
  input wire logic        ext_reset_pin_oe,
  input wire logic        undervolt_monitor_on,
  input wire logic        undervolt_range_select,
  input wire logic        system_clock_enable,
  input wire logic        clock_gen_enable,
  input wire logic        timebase_active,
  input wire logic        cpu_reset,
  input wire logic [15:0] wake_vector,
  input wire logic        wake_strobe
);
  logic [15:0] off_cnt;
  logic        cfg_wr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign cfg_wr = psel && penable && pready && pwrite && paddr == lpwc_pkg::ADDR_CONFIG;

  // Cycles with system clocks held off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      off_cnt <= 16'h0000;
    else if (system_clock_enable)
      off_cnt <= 16'h0000;
    else if (off_cnt != 16'hffff)
      off_cnt <= off_cnt + 16'h0001;
  end

  AST_MON_ON_FROM_RESET: assert property ($rose(presetn) |-> undervolt_monitor_on)
    else $error("monitor off after reset");
  AST_PWR_DISABLE: assert property (cfg_wr && pwdata[2] |=> !undervolt_monitor_on)
    else $error("monitor on while disabled");
  AST_RANGE_RESET: assert property ($rose(presetn) |-> !undervolt_range_select)
    else $error("range not low after reset");
  AST_RANGE_WRITE: assert property (cfg_wr |=> undervolt_range_select == $past(pwdata[5]))
    else $error("range does not follow config");
  AST_HOLD_IN_RESET: assert property (ext_reset_pin_oe |=> cpu_reset)
    else $error("pin driven but cpu not in reset");
  AST_PIN_LOW: assert property (ext_reset_pin_oe |-> !ext_reset_pin_out)
    else $error("reset pin not driven low");
  AST_RECOVERY_MIN: assert property ($rose(system_clock_enable) |-> off_cnt >= 16'd32)
    else $error("stop recovery too short");
  AST_TB_NEEDS_OSC: assert property (timebase_active && !system_clock_enable |-> clock_gen_enable)
    else $error("timebase runs without oscillator");
  AST_VECTOR_RANGE: assert property (wake_strobe |-> wake_vector[15:8] == 8'hff && !wake_vector[0])
    else $error("wake vector outside table");
  AST_STROBE_PULSE: assert property (wake_strobe |=> !wake_strobe)
    else $error("wake strobe longer than one cycle");

  COV_RESET_WAKE: cover property (wake_strobe && wake_vector == lpwc_pkg::VECTOR_RESET);
  COV_STOP_EXIT: cover property ($rose(system_clock_enable));
  COV_UV_HOLD: cover property (ext_reset_pin_oe);
endmodule

bind lpwc_top lpwc_top_properties i_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .ext_reset_pin_out(ext_reset_pin_out),
  .ext_reset_pin_oe(ext_reset_pin_oe), .undervolt_monitor_on(undervolt_monitor_on),
  .undervolt_range_select(undervolt_range_select), .system_clock_enable(system_clock_enable),
  .clock_gen_enable(clock_gen_enable), .timebase_active(timebase_active), .cpu_reset(cpu_reset),
  .wake_vector(wake_vector), .wake_strobe(wake_strobe)
);

// >>> tb/lpwc_peer.sv
// Board side: reset pin with pull-up, free running oscillator.
// Assumes the bench drives the board's reset request.
`timescale 1ns/1ns
module lpwc_peer
(
  input  wire logic drv_n,
  input  wire logic oe,
  input  wire logic out_lvl,
  output logic      pin_n,
  output logic      osc
);
  // pin low from board or device
  assign pin_n = oe ? out_lvl : drv_n;

  // Half period above pclk so no edge is lost
  initial
  begin
    osc = 1'b0;
    forever #13 osc = ~osc;
  end
endmodule

// >>> tb/tb_lpwc_top.sv
// Bench for lpwc_top: APB master, wake sources, comparators.
// Assumes lpwc_peer and the bound checker.
`timescale 1ns/1ns
module tb_lpwc_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        irq_n, emu, brk, wdog, bft, art, rst_drv_n, pin_n, osc, pin_out, pin_oe;
  logic        mon_on, rng, cce, sce, cge, tba, cpu_rst, ws, seen;
  logic [7:0]  paddr, kp;
  logic [31:0] pwdata, prdata, q, d;
  logic [16:0] src;
  logic [15:0] wv;
  int          n_errors, n_compared, cyc, off, k, j, o, p;

  lpwc_top i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_ref_clock(osc),
    .ext_reset_pin_n_in(pin_n), .ext_reset_pin_out(pin_out), .ext_reset_pin_oe(pin_oe),
    .ext_irq_pin_n(irq_n), .keypad_pins(kp), .emulation_mode(emu), .break_req(brk),
    .watchdog_timeout(wdog), .clock_gen_req(src[0]), .first_timer_req(src[3:1]),
    .second_timer_req(src[10:4]), .spi_req(src[12:11]), .async_serial_req(src[15:13]),
    .adc_done_req(src[16]), .below_falling_trip(bft), .above_rising_trip(art),
    .undervolt_monitor_on(mon_on), .undervolt_range_select(rng), .cpu_clock_enable(cce),
    .system_clock_enable(sce), .clock_gen_enable(cge), .timebase_active(tba), .cpu_reset(cpu_rst),
    .wake_vector(wv), .wake_strobe(ws)
  );

  lpwc_peer i_peer (.drv_n(rst_drv_n), .oe(pin_oe), .out_lvl(pin_out), .pin_n(pin_n), .osc(osc));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [15:0] exp_vec(input int i);
    logic [15:0] t [17];
    t = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffd2, 16'hffd0,
          16'hffce, 16'hffcc, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffde};
    return t[i];
  endfunction

  // Oscillator edges to pclk cycles
  function automatic logic in_recov(input int n, input int c);
    return c >= n * 26 / 10 - 3 && c <= n * 26 / 10 + 15;
  endfunction

  task automatic end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
  endtask

  task automatic rd(input logic [7:0] a, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(er, ee);
  endtask

  task automatic wake(input int mx, input logic ex, input logic [15:0] ev);
    seen = 1'b0;
    off = 0;
    for (int i = 0; i < mx && !seen; i++)
    begin
      @(posedge pclk);
      if (sce === 1'b0)
        off++;
      if (ws === 1'b1)
        seen = 1'b1;
    end
    chk(seen, ex);
    if (ex)
      chk(wv, ev);
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    {psel, penable, pwrite, emu, brk, wdog, bft, art, presetn} = '0;
    {irq_n, rst_drv_n} = 2'b11;
    {paddr, kp, pwdata, src} = '0;
    {n_errors, n_compared, cyc} = '0;
    void'($urandom(32'haa71e61e));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(lpwc_pkg::ADDR_CONFIG, 1'b0);
    chk(q, 32'h0);
    rd(lpwc_pkg::ADDR_STATUS, 1'b0);
    chk(q[1:0], 2'h0);
    rd(8'h14, 1'b1);
    d = $urandom & 32'h3d;
    wr(lpwc_pkg::ADDR_CONFIG, d);
    rd(lpwc_pkg::ADDR_CONFIG, 1'b0);
    chk(q, d);
    chk(rng, d[5]);
    wr(lpwc_pkg::ADDR_CONFIG, 32'h0);
    o = $urandom_range(16);
    for (k = 0; k < 17; k++)
    begin
      j = (k + o) % 17;
      wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_WAIT);
      if (k == 0)
        rd(lpwc_pkg::ADDR_TIMEBASE, 1'b1);
      repeat ($urandom_range(6, 1)) @(posedge pclk);
      src[j] <= 1'b1;
      wake(40, 1'b1, exp_vec(j));
      src <= '0;
    end
    wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_WAIT);
    wdog <= 1'b1;
    src[0] <= 1'b1;
    wake(40, 1'b1, 16'hfffe);
    {wdog, src} <= '0;
    repeat (8) @(posedge pclk);
    wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_WAIT);
    brk <= 1'b1;
    wake(30, 1'b0, 16'h0);
    emu <= 1'b1;
    wake(40, 1'b1, 16'hfffc);
    {brk, emu} <= 2'b00;
    wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_WAIT);
    rst_drv_n <= 1'b0;
    wake(40, 1'b1, 16'hfffe);
    rst_drv_n <= 1'b1;
    repeat (8) @(posedge pclk);
    p = $urandom_range(40, 8);
    wr(lpwc_pkg::ADDR_TIMEBASE, 32'h10000 | p);
    wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_WAIT);
    wake(p + 30, 1'b1, 16'hffdc);
    wr(lpwc_pkg::ADDR_TIMEBASE, 32'h0);
    // short recovery with oscillator kept
    wr(lpwc_pkg::ADDR_CONFIG, 32'h3);
    wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_STOP);
    rd(lpwc_pkg::ADDR_TIMEBASE, 1'b1);
    src[16] <= 1'b1;
    wake(30, 1'b0, 16'h0);
    src <= '0;
    irq_n <= 1'b0;
    wake(400, 1'b1, 16'hfffa);
    chk(in_recov(32, off), 1'b1);
    irq_n <= 1'b1;
    wr(lpwc_pkg::ADDR_KEYPAD, 32'h1);
    wr(lpwc_pkg::ADDR_CONFIG, 32'h0);
    wr(lpwc_pkg::ADDR_TIMEBASE, 32'h1ffff);
    wr(lpwc_pkg::ADDR_MODE, lpwc_pkg::CMD_STOP);
    repeat (3) @(posedge pclk);
    chk({cge, tba}, 2'b00);
    kp <= 8'h01;
    wake(12000, 1'b1, 16'hffe0);
    chk(in_recov(4096, off), 1'b1);
    kp <= 8'h00;
    wr(lpwc_pkg::ADDR_TIMEBASE, 32'h0);
    bft <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({pin_oe, cpu_rst, pin_n}, 3'b110);
    bft <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({pin_oe, cpu_rst}, 2'b11);
    art <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({pin_oe, cpu_rst}, 2'b00);
    art <= 1'b0;
    wr(lpwc_pkg::ADDR_CONFIG, 32'h8);
    bft <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(lpwc_pkg::ADDR_STATUS, 1'b0);
    chk({q[1:0], pin_oe}, 3'b010);
    bft <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(lpwc_pkg::ADDR_STATUS, 1'b0);
    chk(q[0], 1'b1);
    art <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(lpwc_pkg::ADDR_STATUS, 1'b0);
    chk(q[0], 1'b0);
    art <= 1'b0;
    wr(lpwc_pkg::ADDR_CONFIG, 32'h24);
    @(posedge pclk);
    chk(mon_on, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(lpwc_pkg::ADDR_CONFIG, 1'b0);
    chk(q, 32'h0);
    chk({rng, mon_on}, 2'b01);
    end_sim();
  end
endmodule
